// ==== pkg/bcs_defines.vh ====
// bcs_defines.vh: constants of the branch/condition special-register block.
// assumes bit 0 of each architected register is its most significant bit;
// the macros below hold the little-endian vector index of each documented bit.
`ifndef BCS_DEFINES_VH
`define BCS_DEFINES_VH

// special register numbers used by move-to / move-from
`define BCS_SPR_IXR 10'h001
`define BCS_SPR_RET 10'h008
`define BCS_SPR_LCNT 10'h009

// reset values
`define BCS_FLG_RST 32'h00000000
`define BCS_IXR_RST 32'h00000000
`define BCS_RET_RST 32'h00000000
`define BCS_LCNT_RST 32'h00000000
`define BCS_BYTES_RST 7'h00
`define BCS_LCNT_ZERO_RST 1'h1

// condition flags register: field n spans vector bits [31-4n -: 4]
`define BCS_FLG_INT_FIELD 3'h0
`define BCS_FLG_FP_FIELD 3'h1
// inside a 4-bit field (vector index within the nibble)
`define BCS_FLD_NEG 3
`define BCS_FLD_POS 2
`define BCS_FLD_ZERO 1
`define BCS_FLD_SO 0

// integer exception register layout
`define BCS_IXR_SO 31
`define BCS_IXR_OV 30
`define BCS_IXR_CARRY 29
`define BCS_IXR_RSV_HI 28
`define BCS_IXR_RSV_LO 7
`define BCS_IXR_BYTES_HI 6
`define BCS_IXR_BYTES_LO 0
// writable bits of the integer exception register
`define BCS_IXR_WMASK 32'hE000007F

// branch options field: vector index of the "do not decrement" bit
`define BCS_BROPT_NO_DECR 2
// low address bits ignored when a register is used as a branch target
`define BCS_TARGET_MASK 32'hFFFFFFFC

`endif

// ==== design/bcs_int_flags.v ====
// bcs_int_flags: derives the integer result flag nibble from a 32-bit result.
// assumes the summary overflow input is already the final state at completion.
`timescale 1ns/1ps
`include "bcs_defines.vh"

module bcs_int_flags (
  // result in
  input wire [31:0] result,
  input wire so_final,
  // flag nibble out
  output reg [3:0] flags
);

  always @* begin
    flags = 4'h0;
    // sign decides negative/positive; zero looks at the raw bit string
    flags[`BCS_FLD_ZERO] = (result == 32'h00000000);
    flags[`BCS_FLD_NEG] = result[31];
    flags[`BCS_FLD_POS] = ~result[31] & (result != 32'h00000000);
    flags[`BCS_FLD_SO] = so_final;
  end

endmodule // bcs_int_flags

// ==== design/bcs_field_merge.v ====
// bcs_field_merge: replaces one 4-bit field of the condition flags register.
// assumes field index 0 is the most significant nibble.
`timescale 1ns/1ps
`include "bcs_defines.vh"

module bcs_field_merge (
  // base value and replacement
  input wire [31:0] word_in,
  input wire [2:0] field,
  input wire [3:0] nibble,
  input wire en,
  // merged value
  output reg [31:0] word_out
);

  integer i;

  always @* begin
    word_out = word_in;
    for (i = 0; i < 8; i = i + 1) begin
      if (en && (field == i[2:0])) begin
        word_out[31 - 4 * i -: 4] = nibble;
      end
    end
  end

endmodule // bcs_field_merge

// ==== design/bcs_branch_regs.v ====
// bcs_branch_regs: condition flags, integer exception, return-address and
// loop-count registers of the integer core.
// assumes completion strobes come from the core's retire stage, one clock,
// and that every strobe describes an instruction completing in that cycle.
//
// Function
// - record-form integer results set first three integer flags by signed compare with zero.
// - negative is bit 0, positive bit 1, zero bit 2; exactly one set.
// - integer flag bit 3 takes the final summary overflow state.
// - negative/positive use signed result; zero uses the raw bit string.
// - flags from a partly undefined result carry no guaranteed value.
// - record-form float instructions copy top four status bits into flag bits 4-7.
// - float flags are any-exception, enabled-exception, invalid-op, overflow at completion.
// - any flag field can be read, copied field to field, written under mask.
// - carrying add/subtract forms set carry on carry out, else clear it.
// - non-carrying ops keep carry; shift right algebraic sets it on lost ones.
// - bits 25-31 of integer exception register hold string byte count.
// - return-address register, number 8, supplies return branch target.
// - return-address low two bits stored but ignored as branch address.
// - link-option branches write next address to return-address register, taken or not.
// - loop-count register, number 9, decrements on request, wrapping zero to all ones.
// - loop-count register supplies the count branch target.
`timescale 1ns/1ps
`include "bcs_defines.vh"

module bcs_branch_regs (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // integer completion
  input wire int_valid,
  input wire int_record,
  input wire [31:0] int_result,
  input wire int_ov_we,
  input wire int_ov,
  input wire int_ca_we,
  input wire int_ca,
  // compare completion
  input wire cmp_valid,
  input wire [2:0] cmp_field,
  input wire [3:0] cmp_flags,
  // floating-point completion
  input wire fp_valid,
  input wire fp_record,
  input wire [3:0] float_status_top,
  // flag field moves
  input wire fld_copy_en,
  input wire [2:0] fld_copy_src,
  input wire [2:0] fld_copy_dst,
  input wire fld_mask_we,
  input wire [7:0] fld_field_mask,
  input wire [31:0] fld_wdata,
  // special register moves
  input wire spr_we,
  input wire spr_re,
  input wire [9:0] spr_num,
  input wire [31:0] spr_wdata,
  // branch completion
  input wire br_valid,
  input wire br_link,
  input wire [4:0] branch_options_field,
  input wire [31:0] br_next_addr,
  // register state
  output reg [31:0] condition_flags_reg,
  output reg [31:0] integer_exception_reg,
  output reg [31:0] return_address_reg,
  output reg [31:0] loop_count_reg,
  // derived outputs
  output reg [6:0] string_byte_count,
  output reg [31:0] return_target_q,
  output reg [31:0] loop_target_q,
  output reg loop_count_zero_q,
  output reg [31:0] spr_rdata_q,
  output reg spr_rvalid_q,
  output reg spr_err_q
);

  // architectural state and its next value
  reg [31:0] flg_q;
  reg [31:0] flg_d;
  reg [31:0] ixr_q;
  reg [31:0] ixr_d;
  reg [31:0] ret_q;
  reg [31:0] ret_d;
  reg [31:0] lcnt_q;
  reg [31:0] lcnt_d;
  // same-cycle merges
  reg [31:0] flg_moved;
  reg [31:0] ixr_moved;
  reg so_final;
  reg [3:0] fp_nibble;
  wire [3:0] int_nibble;
  wire [31:0] flg_after_cmp;
  wire [31:0] flg_after_int;
  wire lcnt_decr;
  wire ixr_wr;
  wire ret_wr;
  wire lcnt_wr;

  // nibble of field f, field 0 at the top of the word
  function [3:0] field_get;
    input [31:0] word;
    input [2:0] f;
    integer k;
    begin
      field_get = 4'h0;
      for (k = 0; k < 8; k = k + 1) begin
        if (f == k[2:0]) begin
          field_get = word[31 - 4 * k -: 4];
        end
      end
    end
  endfunction

  // widen the 8-bit field mask to a 32-bit bit mask
  function [31:0] mask_expand;
    input [7:0] m;
    integer k;
    begin
      mask_expand = 32'h00000000;
      for (k = 0; k < 8; k = k + 1) begin
        mask_expand[31 - 4 * k -: 4] = {4{m[7 - k]}};
      end
    end
  endfunction

  // special register decode
  function spr_known;
    input [9:0] n;
    begin
      spr_known = (n == `BCS_SPR_IXR) || (n == `BCS_SPR_RET) || (n == `BCS_SPR_LCNT);
    end
  endfunction

  // move decode: a strobe qualified by one register number
  function spr_hit;
    input strobe;
    input [9:0] n;
    input [9:0] target;
    begin
      spr_hit = strobe && (n == target);
    end
  endfunction

  // an unknown number matches none of these, so such a write is simply dropped
  assign ixr_wr = spr_hit(spr_we, spr_num, `BCS_SPR_IXR);
  assign ret_wr = spr_hit(spr_we, spr_num, `BCS_SPR_RET);
  assign lcnt_wr = spr_hit(spr_we, spr_num, `BCS_SPR_LCNT);

  // field moves come first, so a completing result in the same cycle wins;
  // a copy reads the old field, and a masked write in the same cycle overrides it
  always @* begin
    flg_moved = flg_q;
    if (fld_copy_en) begin
      flg_moved[31 - 4 * fld_copy_dst -: 4] = field_get(flg_q, fld_copy_src);
    end
    if (fld_mask_we) begin
      flg_moved = (flg_moved & ~mask_expand(fld_field_mask)) |
                  (fld_wdata & mask_expand(fld_field_mask));
    end
  end

  bcs_field_merge u_cmp_merge (
    .word_in(flg_moved),
    .field(cmp_field),
    .nibble(cmp_flags),
    .en(cmp_valid),
    .word_out(flg_after_cmp)
  );

  // a move-to lands before the completing instruction's own updates
  always @* begin
    ixr_moved = ixr_q;
    if (ixr_wr) begin
      ixr_moved = spr_wdata & `BCS_IXR_WMASK;
    end
  end

  // summary overflow is sticky: final state is the moved state or this overflow, set wins
  always @* begin
    so_final = ixr_moved[`BCS_IXR_SO] | (int_valid & int_ov_we & int_ov);
  end

  // an undefined result still yields some flag nibble; software must not rely on it
  bcs_int_flags u_int_flags (
    .result(int_result),
    .so_final(so_final),
    .flags(int_nibble)
  );

  bcs_field_merge u_int_merge (
    .word_in(flg_after_cmp),
    .field(`BCS_FLG_INT_FIELD),
    .nibble(int_nibble),
    .en(int_valid & int_record),
    .word_out(flg_after_int)
  );

  always @* begin
    // status bits arrive in architected order: any, enabled, invalid, overflow
    fp_nibble = float_status_top;
    flg_d = flg_after_int;
    if (fp_valid && fp_record) begin
      flg_d[31 - 4 * `BCS_FLG_FP_FIELD -: 4] = fp_nibble;
    end
  end

  // integer exception register next state
  always @* begin
    ixr_d = ixr_moved;
    if (int_valid && int_ov_we) begin
      ixr_d[`BCS_IXR_OV] = int_ov;
    end
    // the flag nibble copies this same bit, so the two agree after each record-form integer result
    ixr_d[`BCS_IXR_SO] = so_final;
    // the core raises ca_we only for carrying and algebraic-shift instructions
    if (int_valid && int_ca_we) begin
      ixr_d[`BCS_IXR_CARRY] = int_ca;
    end
    ixr_d[`BCS_IXR_RSV_HI:`BCS_IXR_RSV_LO] = 22'h000000;
  end

  // branch decrements when the options field does not suppress it
  assign lcnt_decr = br_valid & ~branch_options_field[`BCS_BROPT_NO_DECR];

  always @* begin
    ret_d = ret_q;
    lcnt_d = lcnt_q;
    if (ret_wr) begin
      ret_d = spr_wdata;
    end
    if (lcnt_wr) begin
      lcnt_d = spr_wdata;
    end
    // branch update beats a move in the same cycle: it retires later in order
    if (br_valid && br_link) begin
      ret_d = br_next_addr;
    end
    // zero minus one wraps to all ones with no special case
    if (lcnt_decr) begin
      lcnt_d = lcnt_q - 32'h00000001;
    end
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      flg_q <= `BCS_FLG_RST;
      ixr_q <= `BCS_IXR_RST;
      ret_q <= `BCS_RET_RST;
      lcnt_q <= `BCS_LCNT_RST;
    end else begin
      flg_q <= flg_d;
      ixr_q <= ixr_d;
      ret_q <= ret_d;
      lcnt_q <= lcnt_d;
    end
  end

  // output copies, all registered from the next-state values;
  // the duplicate flops cost area but keep every port a plain register output
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      condition_flags_reg <= `BCS_FLG_RST;
      integer_exception_reg <= `BCS_IXR_RST;
      return_address_reg <= `BCS_RET_RST;
      loop_count_reg <= `BCS_LCNT_RST;
      string_byte_count <= `BCS_BYTES_RST;
      return_target_q <= `BCS_RET_RST & `BCS_TARGET_MASK;
      loop_target_q <= `BCS_LCNT_RST & `BCS_TARGET_MASK;
      loop_count_zero_q <= `BCS_LCNT_ZERO_RST;
    end else begin
      condition_flags_reg <= flg_d;
      integer_exception_reg <= ixr_d;
      return_address_reg <= ret_d;
      loop_count_reg <= lcnt_d;
      string_byte_count <= ixr_d[`BCS_IXR_BYTES_HI:`BCS_IXR_BYTES_LO];
      return_target_q <= ret_d & `BCS_TARGET_MASK;
      loop_target_q <= lcnt_d & `BCS_TARGET_MASK;
      loop_count_zero_q <= (lcnt_d == 32'h00000000);
    end
  end

  // move-from: value as it stands before this cycle's updates
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      spr_rdata_q <= 32'h00000000;
      spr_rvalid_q <= 1'h0;
      spr_err_q <= 1'h0;
    end else begin
      spr_rvalid_q <= spr_re;
      spr_err_q <= spr_re & ~spr_known(spr_num);
      if (spr_re) begin
        // an unknown number reads zero; the error pulse tells it from a real zero
        case (spr_num)
          `BCS_SPR_IXR: spr_rdata_q <= ixr_q;
          `BCS_SPR_RET: spr_rdata_q <= ret_q;
          `BCS_SPR_LCNT: spr_rdata_q <= lcnt_q;
          default: spr_rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // bcs_branch_regs

// ==== sim/bcs_branch_regs_properties.sv ====
// bcs_branch_regs_properties: port-level checks of the special-register block.
// assumes a single clock domain; bound to the top module at the foot of this file.
`timescale 1ns/1ps
module bcs_branch_regs_properties (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // completions and moves
  input wire int_valid,
  input wire int_record,
  input wire [31:0] int_result,
  input wire int_ca_we,
  input wire int_ca,
  input wire fp_valid,
  input wire fp_record,
  input wire [3:0] float_status_top,
  input wire spr_we,
  input wire br_valid,
  input wire br_link,
  input wire [4:0] branch_options_field,
  input wire [31:0] br_next_addr,
  // register state
  input wire [31:0] condition_flags_reg,
  input wire [31:0] integer_exception_reg,
  input wire [31:0] return_address_reg,
  input wire [31:0] loop_count_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_int_rec;
    int_valid && int_record;
  endsequence
  AST_INT_FLAGS: assert property (
    s_int_rec |=> condition_flags_reg[31:29] == ($past(int_result) == 32'h0 ? 3'h1 :
    $past(int_result[31]) ? 3'h4 : 3'h2)) else $error("integer flags wrong");
  AST_INT_SO: assert property (
    s_int_rec |=> condition_flags_reg[28] == integer_exception_reg[31])
    else $error("summary copy wrong");
  AST_FP_FLAGS: assert property (
    fp_valid && fp_record |=> condition_flags_reg[27:24] == $past(float_status_top))
    else $error("float flags wrong");
  AST_CA_SET: assert property (
    int_valid && int_ca_we && !spr_we |=> integer_exception_reg[29] == $past(int_ca))
    else $error("carry not written");
  AST_CA_KEEP: assert property (
    !(int_valid && int_ca_we) && !spr_we |=> $stable(integer_exception_reg[29]))
    else $error("carry changed");
  AST_RSV_ZERO: assert property (
    integer_exception_reg[28:7] == 22'h0) else $error("reserved bits set");
  AST_LINK: assert property (
    br_valid && br_link |=> return_address_reg == $past(br_next_addr))
    else $error("link address wrong");
  AST_DECR: assert property (
    br_valid && !branch_options_field[2] |=> loop_count_reg == $past(loop_count_reg) - 32'h1)
    else $error("loop count not decremented");
endmodule // bcs_branch_regs_properties

bind bcs_branch_regs bcs_branch_regs_properties bcs_branch_regs_properties_i (.*);

// ==== sim/bcs_branch_regs_bench.sv ====
// bcs_branch_regs_bench: directed sequences through the special-register block.
// assumes the design and its bound checker are compiled first.
`timescale 1ns/1ps
module bcs_branch_regs_bench;
  logic clk = '0, arst_n = '0, int_valid = '0, int_record = '0, int_ov_we = '0, int_ov = '0;
  logic int_ca_we = '0, int_ca = '0, cmp_valid = '0, fp_valid = '0, fp_record = '0;
  logic fld_copy_en = '0, fld_mask_we = '0, spr_we = '0, spr_re = '0;
  logic br_valid = '0, br_link = '0;
  logic [2:0] cmp_field = '0, fld_copy_src = '0, fld_copy_dst = '0;
  logic [3:0] cmp_flags = '0, float_status_top = '0;
  logic [7:0] fld_field_mask = '0;
  logic [9:0] spr_num = '0;
  logic [4:0] branch_options_field = '0;
  logic [31:0] int_result = '0, fld_wdata = '0, spr_wdata = '0, br_next_addr = '0;
  wire [31:0] condition_flags_reg, integer_exception_reg, return_address_reg, loop_count_reg;
  wire [31:0] return_target_q, loop_target_q, spr_rdata_q;
  wire [6:0] string_byte_count;
  wire loop_count_zero_q, spr_rvalid_q, spr_err_q;
  logic [31:0] res_t [5] = '{32'h0, 32'h1, 32'h80000000, 32'hFFFFFFFF, 32'h7FFFFFFF};
  logic [3:0] flg_t [5] = '{4'h2, 4'h4, 4'h8, 4'h8, 4'h4};
  int n_mismatch = 0;
  int checked = 0;
  always #2.5 clk = ~clk;
  bcs_branch_regs bcs_branch_regs_i (.*);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic final_report;
    if (n_mismatch == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // strobes stand for exactly one edge; the #1 lets that edge's updates land
  task automatic go;
    @(posedge clk);
    {int_valid, int_ov_we, int_ca_we, cmp_valid, fp_valid, fld_copy_en, fld_mask_we, spr_we,
      spr_re, br_valid} <= '0;
    #1;
  endtask
  task automatic iop(input logic [31:0] r, input logic rec, ovw, ov, caw, ca);
    @(posedge clk);
    int_valid <= 1'h1;
    int_result <= r;
    int_record <= rec;
    int_ov_we <= ovw;
    int_ov <= ov;
    int_ca_we <= caw;
    int_ca <= ca;
    go;
  endtask
  task automatic spr_wr(input logic [9:0] n, input logic [31:0] d);
    @(posedge clk);
    spr_we <= 1'h1;
    spr_num <= n;
    spr_wdata <= d;
    go;
  endtask
  task automatic spr_rd(input logic [9:0] n, input logic [31:0] e, input logic er);
    @(posedge clk);
    spr_re <= 1'h1;
    spr_num <= n;
    go;
    chk(spr_rdata_q, e);
    chk(32'({spr_rvalid_q, spr_err_q}), 32'({1'h1, er}));
  endtask
  task automatic brn(input logic lnk, input logic [4:0] bo, input logic [31:0] na);
    @(posedge clk);
    br_valid <= 1'h1;
    br_link <= lnk;
    branch_options_field <= bo;
    br_next_addr <= na;
    go;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'h1;
    #1;
    chk(condition_flags_reg, 32'h0);
    foreach (res_t[i]) begin
      iop(res_t[i], 1'h1, 1'h0, 1'h0, 1'h0, 1'h0);
      chk(32'(condition_flags_reg[31:28]), 32'(flg_t[i]));
    end
    // overflow raised by the same instruction must already show in the copy
    iop(32'h0, 1'h1, 1'h1, 1'h1, 1'h0, 1'h0);
    chk(32'(condition_flags_reg[31:28]), 32'h3);
    iop(32'h5, 1'h0, 1'h0, 1'h0, 1'h1, 1'h1);
    chk(32'(integer_exception_reg[29]), 32'h1);
    @(posedge clk);
    cmp_valid <= 1'h1;
    cmp_field <= 3'h3;
    cmp_flags <= 4'hA;
    go;
    chk(32'(integer_exception_reg[29]), 32'h1);
    iop(32'h0, 1'h0, 1'h0, 1'h0, 1'h1, 1'h0);
    chk(32'(integer_exception_reg[29]), 32'h0);
    @(posedge clk);
    fp_valid <= 1'h1;
    fp_record <= 1'h1;
    float_status_top <= 4'hB;
    go;
    chk(32'(condition_flags_reg[27:24]), 32'hB);
    @(posedge clk);
    fld_mask_we <= 1'h1;
    fld_field_mask <= 8'h81;
    fld_wdata <= 32'h12345678;
    go;
    chk(condition_flags_reg & 32'hFF0F000F, 32'h1B0A0008);
    @(posedge clk);
    fld_copy_en <= 1'h1;
    fld_copy_src <= 3'h7;
    fld_copy_dst <= 3'h2;
    go;
    chk(32'(condition_flags_reg[23:20]), 32'h8);
    spr_wr(10'h001, 32'hFFFFFFFF);
    spr_rd(10'h001, 32'hE000007F, 1'h0);
    chk(32'(string_byte_count), 32'h7F);
    spr_wr(10'h008, 32'h1003);
    spr_rd(10'h008, 32'h1003, 1'h0);
    chk(return_target_q, 32'h1000);
    spr_wr(10'h009, 32'h0);
    chk(32'(loop_count_zero_q), 32'h1);
    brn(1'h1, 5'h00, 32'h2000);
    chk(return_address_reg, 32'h2000);
    chk(loop_count_reg, 32'hFFFFFFFF);
    brn(1'h0, 5'h04, 32'h3000);
    chk(return_address_reg, 32'h2000);
    chk(loop_count_reg, 32'hFFFFFFFF);
    chk(32'(loop_count_zero_q), 32'h0);
    chk(loop_target_q, 32'hFFFFFFFC);
    spr_rd(10'h003, 32'h0, 1'h1);
    final_report;
  end
endmodule // bcs_branch_regs_bench
